// *** core/txws_pkg.sv ***
// Constants for the transmit waveform shaping configuration bank
package txws_pkg;
  // ==========================================================
  // Channel map (register index space, byte address = 4 x index)
  localparam int          NCH           = 22;
  localparam logic [10:0] CH_STRIDE_IDX = 11'h040;
  localparam logic [10:0] CH0_BASE_IDX  = 11'h7c0;
  localparam logic [5:0]  OFF_SCALE     = 6'h07;
  localparam logic [5:0]  OFF_RAM_CTRL  = 6'h08;
  localparam logic [5:0]  OFF_SAMPLE    = 6'h09;
  localparam logic [5:0]  OFF_TSEL      = 6'h0c;
  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0]  SCALE_RST     = 8'h36;
  localparam logic [7:0]  RAM_CTRL_RST  = 8'h00;
  localparam logic [7:0]  SAMPLE_RST    = 8'h00;
  localparam logic [3:0]  TSEL_RST      = 4'h0;
  localparam int          RAM_EN_BIT    = 6;
  localparam int          RAM_DIR_BIT   = 5;
  localparam int          TSEL_ARB_BIT  = 3;
  // ==========================================================
  // Template RAM and amplitude scaling
  localparam int          SLOT_BITS     = 5;
  localparam logic [4:0]  LAST_SAMPLE   = 5'h13;
  localparam logic [5:0]  NOMINAL_SCALE = 6'h21;
  localparam logic [19:0] SCALE_MULT    = 20'h0003e;
  localparam logic [19:0] SCALE_ROUND   = 20'h00400;
  localparam int          SCALE_SHIFT   = 11;
  // ==========================================================
  // AXI4-Lite responses and read sequencing
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_LOAD, RD_RESP} txws_rd_t;
endpackage : txws_pkg

// *** core/txws_ram.sv ***
// Template sample memory, one write/read port and one read-only port
`timescale 1ns/1ps
module txws_ram #(
  parameter int AW = 10,
  parameter int DW = 7
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Register side port
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [DW-1:0] a_wdata,
  output logic      [DW-1:0] a_rdata,
  // Pulse generator port
  input  wire logic [AW-1:0] b_addr,
  output logic      [DW-1:0] b_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ==========================================================
  // Storage
  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end

  // ==========================================================
  // Registered read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end
endmodule : txws_ram

// *** core/txws_scale.sv ***
// Amplitude scaler applying the six-bit scale factor to a template sample
`timescale 1ns/1ps
module txws_scale (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Sample in
  input  wire logic       arb,
  input  wire logic [6:0] sample,
  input  wire logic [5:0] scale,
  // Scaled level out
  output logic      [7:0] level
);
  logic signed [19:0] prod;

  // ==========================================================
  // Gain = scale / 33, one code is about 3 percent
  always_comb begin
    prod = 20'(signed'(sample)) * signed'(20'(scale)) * signed'(txws_pkg::SCALE_MULT)
           + signed'(txws_pkg::SCALE_ROUND);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= '0;
    end else begin
      level <= arb ? 8'(prod >>> txws_pkg::SCALE_SHIFT) : 8'h00;
    end
  end

  // ==========================================================
  // Checks
  nominal_gain_a: assert property (@(posedge clk) disable iff (!rst_n)
    arb && scale == txws_pkg::NOMINAL_SCALE |=> level == {$past(sample[6]), $past(sample)})
    else $error("nominal scale does not pass sample unchanged");
  zero_gain_a: assert property (@(posedge clk) disable iff (!rst_n)
    scale == 6'h00 |=> level == 8'h00)
    else $error("scale zero does not give zero level");
endmodule : txws_scale

// *** core/txws_bank.sv ***
// Per-channel transmit waveform shaping register bank with AXI4-Lite access
// Function
// - Each of 22 channels has its own registers; ch1..21 stride 0x40, ch0 apart.
// - Scale register holds six-bit factor, upper bits reserved, resets to 0x36.
// - Scale code 100001 gives nominal unscaled amplitude.
// - Each scale step away from nominal changes amplitude by about three percent.
// - Scale range spans minus one hundred percent (code 0) to about plus ninety percent (code 63) of nominal.
// - RAM enable, direction, address and data only act when template select is 1XXX.
// - RAM control bit 6 enables template RAM access; reset disables.
// - RAM control bit 5 selects direction: zero writes, one reads.
// - Sample address bits 4..0; codes 19 and above all select sample 19.
// - Sample data bits 6..0 are stored at the current sample address.
// - Sample data field changes only when software writes it.
// - Both RAM control registers read and write, resetting to 0x00.
// - Template select 0000/0001 presets, 1XXX arbitrary waveform, others reserved.
`timescale 1ns/1ps
module txws_bank #(
  parameter int NCH = txws_pkg::NCH
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // AXI4-Lite write address and data
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Pulse generator template fetch
  input  wire logic [4:0]  PG_CH,
  input  wire logic [4:0]  PG_ADDR,
  output logic [7:0]       PG_LEVEL
);
  // ==========================================================
  // Parameter check
  if (NCH < 2 || NCH > 32) begin : g_bad_nch
    $error("NCH must lie in 2..32");
  end

  // ==========================================================
  // Declarations
  logic [31:0]        aw_addr_ff;
  logic               aw_full_ff;
  logic [7:0]         w_data_ff;
  logic               w_strb_ff;
  logic               w_full_ff;
  logic [31:0]        ar_addr_ff;
  txws_pkg::txws_rd_t rd_st_ff;
  logic [5:0]         scale_ff   [NCH];
  logic               en_ff      [NCH];
  logic               dir_ff     [NCH];
  logic [4:0]         saddr_ff   [NCH];
  logic [6:0]         sdata_ff   [NCH];
  logic [3:0]         tsel_ff    [NCH];
  logic [11:0]        wr_dec;
  logic [11:0]        rd_dec;
  logic               wr_commit;
  logic [4:0]         wr_ch;
  logic [4:0]         rd_ch;
  logic               ram_we;
  logic [9:0]         ram_a_addr;
  logic [6:0]         ram_a_q;
  logic [6:0]         ram_b_q;
  logic [4:0]         pg_ch_ff;
  logic               pg_ok_ff;
  logic               rd_arb;
  logic [31:0]        nxt_rdata;

  // ==========================================================
  // Address decode: {hit, channel, offset}
  function automatic logic [11:0] decode(input logic [31:0] a);
    logic [10:0] idx;
    logic [4:0]  ch;
    logic        hit;
    idx = a[12:2];
    ch  = 5'h00;
    hit = 1'b0;
    if (a[31:13] == 19'h00000 && a[1:0] == 2'h0) begin
      if (idx >= txws_pkg::CH0_BASE_IDX) begin
        hit = 1'b1;
      end else if (idx < 11'(NCH - 1) * txws_pkg::CH_STRIDE_IDX) begin
        hit = 1'b1;
        ch  = idx[10:6] + 5'h01;
      end
    end
    hit = hit && (idx[5:0] == txws_pkg::OFF_SCALE || idx[5:0] == txws_pkg::OFF_RAM_CTRL ||
                  idx[5:0] == txws_pkg::OFF_SAMPLE || idx[5:0] == txws_pkg::OFF_TSEL);
    return {hit, ch, idx[5:0]};
  endfunction : decode

  // Sample address saturation
  function automatic logic [4:0] clamp(input logic [4:0] s);
    return (s > txws_pkg::LAST_SAMPLE) ? txws_pkg::LAST_SAMPLE : s;
  endfunction : clamp

  assign wr_dec    = decode(aw_addr_ff);
  assign rd_dec    = decode(ar_addr_ff);
  assign wr_ch     = wr_dec[10:6];
  assign rd_ch     = rd_dec[10:6];
  assign wr_commit = aw_full_ff && w_full_ff && !S_AXI_BVALID && rd_st_ff != txws_pkg::RD_FETCH;

  // ==========================================================
  // Write address and data capture
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_full_ff    <= 1'b0;
      aw_addr_ff    <= '0;
      S_AXI_AWREADY <= 1'b1;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_full_ff    <= 1'b1;
      aw_addr_ff    <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      aw_full_ff    <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      w_full_ff    <= 1'b0;
      w_data_ff    <= '0;
      w_strb_ff    <= 1'b0;
      S_AXI_WREADY <= 1'b1;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_full_ff    <= 1'b1;
      w_data_ff    <= S_AXI_WDATA[7:0];
      w_strb_ff    <= S_AXI_WSTRB[0];
      S_AXI_WREADY <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      w_full_ff    <= 1'b0;
      S_AXI_WREADY <= 1'b1;
    end
  end

  // ==========================================================
  // Write response
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= txws_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_dec[11] ? txws_pkg::RESP_OKAY : txws_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ==========================================================
  // Per-channel registers
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic sel;
    assign sel = wr_commit && wr_dec[11] && w_strb_ff && wr_ch == 5'(g);
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        scale_ff[g] <= txws_pkg::SCALE_RST[5:0];
        en_ff[g]    <= txws_pkg::RAM_CTRL_RST[txws_pkg::RAM_EN_BIT];
        dir_ff[g]   <= txws_pkg::RAM_CTRL_RST[txws_pkg::RAM_DIR_BIT];
        saddr_ff[g] <= txws_pkg::RAM_CTRL_RST[4:0];
        sdata_ff[g] <= txws_pkg::SAMPLE_RST[6:0];
        tsel_ff[g]  <= txws_pkg::TSEL_RST;
      end else if (sel) begin
        unique case (wr_dec[5:0])
          txws_pkg::OFF_SCALE: begin
            scale_ff[g] <= w_data_ff[5:0];
          end
          txws_pkg::OFF_RAM_CTRL: begin
            en_ff[g]    <= w_data_ff[txws_pkg::RAM_EN_BIT];
            dir_ff[g]   <= w_data_ff[txws_pkg::RAM_DIR_BIT];
            saddr_ff[g] <= w_data_ff[4:0];
          end
          txws_pkg::OFF_SAMPLE: begin
            sdata_ff[g] <= w_data_ff[6:0];
          end
          default: begin
            tsel_ff[g]  <= w_data_ff[3:0];
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Template RAM, 32 slots per channel, 20 used
  assign ram_we = wr_commit && wr_dec[11] && w_strb_ff && wr_dec[5:0] == txws_pkg::OFF_SAMPLE
                  && tsel_ff[wr_ch][txws_pkg::TSEL_ARB_BIT]
                  && en_ff[wr_ch] && !dir_ff[wr_ch];
  assign ram_a_addr = wr_commit ? {wr_ch, clamp(saddr_ff[wr_ch])}
                                : {rd_ch, clamp(saddr_ff[rd_ch])};

  txws_ram #(
    .AW (10),
    .DW (7)
  ) u_ram (
    .clk     (CLK),
    .rst_n   (RST_N),
    .a_we    (ram_we),
    .a_addr  (ram_a_addr),
    .a_wdata (w_data_ff[6:0]),
    .a_rdata (ram_a_q),
    .b_addr  ({PG_CH, clamp(PG_ADDR)}),
    .b_rdata (ram_b_q)
  );

  // ==========================================================
  // Read channel
  assign rd_arb = tsel_ff[rd_ch][txws_pkg::TSEL_ARB_BIT] && en_ff[rd_ch] && dir_ff[rd_ch];

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (rd_dec[11]) begin
      unique case (rd_dec[5:0])
        txws_pkg::OFF_SCALE: begin
          nxt_rdata[5:0] = scale_ff[rd_ch];
        end
        txws_pkg::OFF_RAM_CTRL: begin
          nxt_rdata[6:0] = {en_ff[rd_ch], dir_ff[rd_ch], saddr_ff[rd_ch]};
        end
        txws_pkg::OFF_SAMPLE: begin
          nxt_rdata[6:0] = rd_arb ? ram_a_q : sdata_ff[rd_ch];
        end
        default: begin
          nxt_rdata[3:0] = tsel_ff[rd_ch];
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_st_ff      <= txws_pkg::RD_IDLE;
      ar_addr_ff    <= '0;
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= txws_pkg::RESP_OKAY;
    end else begin
      unique case (rd_st_ff)
        txws_pkg::RD_IDLE: begin
          if (S_AXI_ARVALID) begin
            ar_addr_ff    <= S_AXI_ARADDR;
            S_AXI_ARREADY <= 1'b0;
            rd_st_ff      <= txws_pkg::RD_FETCH;
          end
        end
        txws_pkg::RD_FETCH: begin
          rd_st_ff <= txws_pkg::RD_LOAD;
        end
        txws_pkg::RD_LOAD: begin
          S_AXI_RDATA  <= nxt_rdata;
          S_AXI_RRESP  <= rd_dec[11] ? txws_pkg::RESP_OKAY : txws_pkg::RESP_SLVERR;
          S_AXI_RVALID <= 1'b1;
          rd_st_ff     <= txws_pkg::RD_RESP;
        end
        txws_pkg::RD_RESP: begin
          if (S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
            rd_st_ff      <= txws_pkg::RD_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Pulse generator path
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pg_ch_ff <= '0;
      pg_ok_ff <= 1'b0;
    end else begin
      pg_ch_ff <= PG_CH;
      pg_ok_ff <= PG_CH < 5'(NCH);
    end
  end

  txws_scale u_scale (
    .clk    (CLK),
    .rst_n  (RST_N),
    .arb    (pg_ok_ff && tsel_ff[pg_ch_ff][txws_pkg::TSEL_ARB_BIT]),
    .sample (ram_b_q),
    .scale  (scale_ff[pg_ch_ff]),
    .level  (PG_LEVEL)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence ar_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence rd_answer;
    !S_AXI_RVALID ##1 !S_AXI_RVALID ##1 !S_AXI_RVALID ##1 S_AXI_RVALID;
  endsequence

  read_latency_a: assert property (ar_taken |-> rd_answer)
    else $error("read answer not three cycles after address");
  write_resp_a: assert property (wr_commit |=> S_AXI_BVALID)
    else $error("write response missing after commit");
  ram_gate_a: assert property (ram_we |-> tsel_ff[wr_ch][3] && en_ff[wr_ch]
    && !dir_ff[wr_ch]) else $error("RAM written outside enabled write mode");
  ram_dir_a: assert property (ram_we |-> !dir_ff[wr_ch])
    else $error("RAM written in read direction");
  slot_clamp_a: assert property (ram_we |-> ram_a_addr[4:0] <= txws_pkg::LAST_SAMPLE)
    else $error("sample slot beyond last");
  data_hold_a: assert property (!(wr_commit && wr_ch == 5'h00
    && wr_dec[5:0] == txws_pkg::OFF_SAMPLE) |=> $stable(sdata_ff[0]))
    else $error("sample data changed without a write");
  scale_store_a: assert property (wr_commit && wr_dec[11] && w_strb_ff && wr_ch == 5'h01
    && wr_dec[5:0] == txws_pkg::OFF_SCALE |=> scale_ff[1] == $past(w_data_ff[5:0]))
    else $error("scale factor not stored");
  reserved_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:7] == 25'h0000000)
    else $error("reserved read bits not zero");
  ram_readback_a: assert property (rd_st_ff == txws_pkg::RD_LOAD && rd_dec[11] && rd_arb
    && rd_dec[5:0] == txws_pkg::OFF_SAMPLE |=> S_AXI_RDATA[6:0] == $past(ram_a_q))
    else $error("read mode does not return RAM sample");
endmodule : txws_bank

// *** dv/txws_bank_tb.sv ***
// Self-checking bench for the transmit waveform shaping register bank
`timescale 1ns/1ps
module txws_bank_tb;
  // ==========================================================
  // Clock, reset and stimulus
  logic        CLK     = 1'b0;
  logic        RST_N   = 1'b0;
  logic [31:0] awaddr  = 32'h0;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] araddr  = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [3:0]  wstrb   = 4'h1;
  logic [4:0]  pg_ch   = 5'h05;
  logic [4:0]  pg_addr = 5'h00;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  pg_level;
  logic [31:0] seed    = 32'h000035b1;
  logic [6:0]  mem [2][20];
  logic [7:0]  sc [22];
  int          num_errors = 0;
  int          checks     = 0;

  always #12.5 CLK = ~CLK;

  txws_bank uut (
    .CLK(CLK), .RST_N(RST_N),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PG_CH(pg_ch), .PG_ADDR(pg_addr), .PG_LEVEL(pg_level)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] ra(input int ch, input logic [5:0] off);
    logic [10:0] b;
    b = (ch == 0) ? 11'h7c0 : 11'(11'h040 * (ch - 1));
    return {19'h0, b + {5'h0, off}, 2'h0};
  endfunction : ra

  function automatic logic [7:0] lvl(input logic [6:0] s, input logic [5:0] g);
    int p;
    p = int'($signed(s)) * int'({26'h0, g}) * 62 + 1024;
    return 8'(p >>> 11);
  endfunction : lvl

  task automatic conclude;
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic hang;
    num_errors++;
    conclude();
  endtask : hang

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  // ==========================================================
  // AXI4-Lite master
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rs;
    int n;
    tb = 1'b0;
    n = 0;
    rs = 2'h0;
    @(posedge CLK);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h0, d};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!tb && n < 100) begin
      @(negedge CLK);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge CLK);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      n++;
    end
    if (!tb) hang();
    chk_resp(rs, er);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ta, tr;
    int n;
    tr = 1'b0;
    n = 0;
    d = 32'h0;
    rs = 2'h0;
    @(posedge CLK);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!tr && n < 100) begin
      @(negedge CLK);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge CLK);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      n++;
    end
    if (!tr) hang();
  endtask : rd

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] rs;
    rd(a, d, rs);
    chk_val(d, exp);
    chk_resp(rs, txws_pkg::RESP_OKAY);
  endtask : rchk

  task automatic pgchk(input logic [4:0] ch, input logic [4:0] sl, input logic [7:0] exp);
    @(posedge CLK);
    pg_ch   <= ch;
    pg_addr <= sl;
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    chk_val({24'h0, pg_level}, {24'h0, exp});
  endtask : pgchk

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  v;
    logic [5:0]  gl [5];
    int          c;
    gl = '{6'h21, 6'h22, 6'h20, 6'h00, 6'h3f};
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    for (int k = 0; k < 22; k += 21) begin
      rchk(ra(k, txws_pkg::OFF_SCALE), 32'h36);
      rchk(ra(k, txws_pkg::OFF_RAM_CTRL), 32'h0);
      rchk(ra(k, txws_pkg::OFF_SAMPLE), 32'h0);
    end
    // Per-channel scale registers, reserved bits dropped
    for (int k = 0; k < 22; k++) begin
      sc[k] = 8'(rnd());
      wr(ra(k, txws_pkg::OFF_SCALE), sc[k], txws_pkg::RESP_OKAY);
    end
    for (int k = 0; k < 22; k++) rchk(ra(k, txws_pkg::OFF_SCALE), {26'h0, sc[k][5:0]});
    // Unmapped, misaligned and strobe-less accesses
    wr(ra(22, txws_pkg::OFF_SCALE), 8'h21, txws_pkg::RESP_SLVERR);
    wr(ra(1, txws_pkg::OFF_SCALE) + 32'h1, 8'h00, txws_pkg::RESP_SLVERR);
    rd(ra(1, 6'h05), d, r);
    chk_val(d, 32'h0);
    chk_resp(r, txws_pkg::RESP_SLVERR);
    wr(ra(1, txws_pkg::OFF_SCALE) | 32'h00002000, ~sc[1], txws_pkg::RESP_SLVERR);
    wstrb <= 4'h0;
    wr(ra(1, txws_pkg::OFF_SCALE), ~sc[1], txws_pkg::RESP_OKAY);
    wstrb <= 4'h1;
    rchk(ra(1, txws_pkg::OFF_SCALE), {26'h0, sc[1][5:0]});
    // Control and sample fields with the arbitrary template off
    v = 8'(rnd());
    wr(ra(5, txws_pkg::OFF_RAM_CTRL), v, txws_pkg::RESP_OKAY);
    rchk(ra(5, txws_pkg::OFF_RAM_CTRL), {25'h0, v[6:0]});
    v = 8'(rnd());
    wr(ra(5, txws_pkg::OFF_SAMPLE), v, txws_pkg::RESP_OKAY);
    repeat (2) rchk(ra(5, txws_pkg::OFF_SAMPLE), {25'h0, v[6:0]});
    // Fill two private template memories
    for (int k = 0; k < 2; k++) begin
      c = k * 21;
      wr(ra(c, txws_pkg::OFF_TSEL), 8'h08 | (8'(rnd()) & 8'h07), txws_pkg::RESP_OKAY);
      for (int s = 0; s < 20; s++) begin
        mem[k][s] = 7'(rnd());
        wr(ra(c, txws_pkg::OFF_RAM_CTRL), 8'h40 | 8'(s), txws_pkg::RESP_OKAY);
        wr(ra(c, txws_pkg::OFF_SAMPLE), {1'b0, mem[k][s]}, txws_pkg::RESP_OKAY);
      end
    end
    mem[0][19] = 7'(rnd());
    wr(ra(0, txws_pkg::OFF_RAM_CTRL), 8'h5f, txws_pkg::RESP_OKAY);
    wr(ra(0, txws_pkg::OFF_SAMPLE), {1'b0, mem[0][19]}, txws_pkg::RESP_OKAY);
    // Access disabled: field kept, memory untouched
    wr(ra(0, txws_pkg::OFF_RAM_CTRL), 8'h23, txws_pkg::RESP_OKAY);
    wr(ra(0, txws_pkg::OFF_SAMPLE), {1'b0, ~mem[0][3]}, txws_pkg::RESP_OKAY);
    rchk(ra(0, txws_pkg::OFF_SAMPLE), {25'h0, ~mem[0][3]});
    // Template select cleared: enable, direction and data ignored
    wr(ra(21, txws_pkg::OFF_TSEL), 8'h07, txws_pkg::RESP_OKAY);
    rchk(ra(21, txws_pkg::OFF_TSEL), 32'h00000007);
    wr(ra(21, txws_pkg::OFF_RAM_CTRL), 8'h43, txws_pkg::RESP_OKAY);
    wr(ra(21, txws_pkg::OFF_SAMPLE), {1'b0, ~mem[1][3]}, txws_pkg::RESP_OKAY);
    wr(ra(21, txws_pkg::OFF_RAM_CTRL), 8'h63, txws_pkg::RESP_OKAY);
    rchk(ra(21, txws_pkg::OFF_SAMPLE), {25'h0, ~mem[1][3]});
    pgchk(5'd21, 5'd3, 8'h00);
    wr(ra(21, txws_pkg::OFF_TSEL), 8'h0f, txws_pkg::RESP_OKAY);
    // Read back both memories, including clamped slots
    for (int k = 0; k < 2; k++) begin
      for (int s = 0; s < 21; s++) begin
        wr(ra(k * 21, txws_pkg::OFF_RAM_CTRL), 8'h60 | 8'(s == 20 ? 22 : s), 2'h0);
        rchk(ra(k * 21, txws_pkg::OFF_SAMPLE), {25'h0, mem[k][s > 19 ? 19 : s]});
      end
    end
    // Pulse path amplitude over scale codes
    foreach (gl[i]) begin
      wr(ra(21, txws_pkg::OFF_SCALE), {2'h0, gl[i]}, txws_pkg::RESP_OKAY);
      for (int s = 0; s < 20; s += 3) pgchk(5'd21, 5'(s), lvl(mem[1][s], gl[i]));
    end
    v = 8'(rnd());
    wr(ra(0, txws_pkg::OFF_SCALE), v, txws_pkg::RESP_OKAY);
    pgchk(5'd0, 5'h1f, lvl(mem[0][19], v[5:0]));
    pgchk(5'd5, 5'd0, 8'h00);
    conclude();
  end
endmodule : txws_bank_tb
